// ===== ocu_defs.vh
// Constants for the output compare timer unit: register offsets,
// field positions, reset values and mode and select encodings.
// Assumes an APB slave with 8-bit byte addresses and 32-bit data.
`ifndef OCU_DEFS_VH
`define OCU_DEFS_VH

// Register byte offsets
`define OCU_ADDR_CTL_ONE 8'h00
`define OCU_ADDR_CTL_TWO 8'h04
`define OCU_ADDR_PRIMARY 8'h08
`define OCU_ADDR_SECONDARY 8'h0c
`define OCU_ADDR_COUNTER 8'h10
`define OCU_ADDR_STATUS 8'h14

// Control one fields
`define OCU_TBSEL_MSB 12
`define OCU_TBSEL_LSB 10
`define OCU_TRIG_CLR_BIT 3
`define OCU_MODE_MSB 2
`define OCU_MODE_LSB 0

// Control two fields
`define OCU_CASCADE_BIT 8
`define OCU_TRIG_SEL_BIT 7
`define OCU_TRIG_STAT_BIT 6
`define OCU_SYNC_MSB 4
`define OCU_SYNC_LSB 0

// Status fields
`define OCU_FLAG_BIT 0
`define OCU_PIN_BIT 1

// Reset values
`define OCU_CTL_ONE_RST 16'h0000
`define OCU_CTL_TWO_RST 16'h0000
`define OCU_VALUE_RST 16'h0000

// Compare mode encodings
`define OCU_MODE_OFF 3'h0
`define OCU_MODE_ONE_HIGH 3'h1
`define OCU_MODE_ONE_LOW 3'h2
`define OCU_MODE_TOGGLE 3'h3
`define OCU_MODE_DBL_SHOT 3'h4
`define OCU_MODE_DBL_CONT 3'h5
`define OCU_MODE_PWM_EDGE 3'h6
`define OCU_MODE_PWM_CENTER 3'h7

// Time base select encodings
`define OCU_TB_SYSCLK 3'h7
`define OCU_TB_TIMERS 3'h4

// Sync source encodings
`define OCU_SYNC_NONE 5'h00
`define OCU_SYNC_SELF 5'h1f

// Counter limits
`define OCU_CNT_MAX 16'hffff
`define OCU_CNT_ZERO 16'h0000

`endif

// ===== ocu_pin_load.sv
// Load on the compare output pin: counts cycles the pin is high.
// Assumes the pin is a level synchronous to pclk.
`default_nettype none
module ocu_pin_load (
   input wire logic pclk,
   input wire logic clr,
   input wire logic pin,
   output var logic [15:0] high_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge pclk)
   begin
      if (clr)
         high_cnt <= 16'h0;
      else if (pin)
         high_cnt <= high_cnt + 16'h1;
   end
endmodule // ocu_pin_load
`default_nettype wire

// ===== ocu_sync_sel.v
// Sync source selector: picks one event from the sync source vector.
// Assumes events are one-cycle pulses; the top value means this unit.
`default_nettype none
`include "ocu_defs.vh"

module ocu_sync_sel (
   input wire [4:0] sync_source_select,
   input wire [30:1] sync_event_in,
   input wire self_event,
   output reg sync_event
);

   // Code zero means no source, the top code means own period end
   always @*
   begin
      if (sync_source_select == `OCU_SYNC_NONE)
         sync_event = 1'b0;
      else if (sync_source_select == `OCU_SYNC_SELF)
         sync_event = self_event;
      else
         sync_event = sync_event_in[sync_source_select];
   end

endmodule // ocu_sync_sel
`default_nettype wire

// ===== ocu_tick_sel.v
// Time base selector: turns the selected source into a count enable.
// Assumes each timer tick input is a one-cycle pulse on pclk.
`default_nettype none
`include "ocu_defs.vh"

module ocu_tick_sel (
   input wire [2:0] time_base_select,
   input wire [4:0] timer_tick,
   output reg tick
);

   // System clock counts every cycle, timers by their tick, rest idle
   always @*
   begin
      if (time_base_select == `OCU_TB_SYSCLK)
         tick = 1'b1;
      else if (time_base_select <= `OCU_TB_TIMERS)
         tick = timer_tick[time_base_select];
      else
         tick = 1'b0;
   end

endmodule // ocu_tick_sel
`default_nettype wire

// ===== ocu_unit.v
// Output compare timer unit: APB registers, 16-bit counter, compare
// and PWM output logic, trigger and cascade handling.
// Assumes one pclk domain; tick and sync inputs are pclk pulses.
//
// Summary of operation
// - Free-running counter counts up on time base ticks, wrapping to zero.
// - Each counter match with primary or secondary value is an event.
// - Synchronous operation runs once enabled; sync event clears counter.
// - Trigger operation holds counter clear until a sync event arrives.
// - Sync select zero means free-running; nonzero means sync or trigger.
// - Trigger mode select bit picks trigger when set, sync when clear.
// - Odd unit holds low half, even unit high half when cascaded.
// - Low-half counter roll-over increments the high-half counter.
// - Cascade works only when both paired units set cascade enable.
// - Pin rests in default state, flips on primary match.
// - Double compare returns pin to default on secondary match.
// - Flag on primary match single modes, secondary match double modes.
// - Single-shot fires once until control one rewritten; continuous repeats.
// - Mode values with top bit zero are compare operations.
// - PWM compare values pass through hidden shadow registers.
// - Edge PWM: primary sets on-time, secondary sets period.
// - Center PWM takes period from the sync source timer.
// - Trigger clear mode clears trigger status on secondary match.
// - Mode 111 is center PWM, mode 110 is edge PWM.
// - Modes 101 and 100 toggle on alternate matches, continuous or once.
// - PWM value writes take effect after the current period ends.
`default_nettype none
`include "ocu_defs.vh"

module ocu_unit (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [4:0] timer_tick,
   input wire [30:1] sync_event_in,
   input wire [15:0] timer_period_value,
   input wire casc_high_half,
   input wire casc_peer_enable,
   input wire casc_carry_in,
   input wire casc_peer_pri_eq,
   input wire casc_peer_sec_eq,
   output wire casc_enable_out,
   output reg casc_carry_out,
   output wire casc_pri_eq,
   output wire casc_sec_eq,
   output wire period_event,
   output wire compare_interrupt_flag,
   output wire compare_output_pin
);

   reg [15:0] ctl_one_q;
   reg [15:0] ctl_two_q;
   reg [15:0] primary_compare_value_q;
   reg [15:0] secondary_compare_value_q;
   reg [15:0] pri_shadow_q;
   reg [15:0] sec_shadow_q;
   reg [15:0] compare_counter_q;
   reg [15:0] compare_counter_d;
   reg fresh_q;
   reg armed_q;
   reg half_q;
   reg pin_q;
   reg pin_d;
   reg flag_q;
   reg trig_stat_q;
   reg load_req_q;
   wire tick;
   wire sync_event;
   wire [2:0] compare_mode_select;
   wire [2:0] time_base_select;
   wire trigger_clear_mode;
   wire cascade_enable;
   wire trigger_mode_select;
   wire [4:0] sync_source_select;
   wire wr_en;
   wire ctl_one_wr;
   wire ctl_two_wr;
   wire stat_wr;
   wire addr_ok;
   wire enabled;
   wire synced;
   wire trig_op;
   wire cascaded;
   wire high_role;
   wire step;
   wire held;
   wire sync_reset;
   wire [15:0] pri_val;
   wire [15:0] sec_val;
   wire pri_eq;
   wire sec_eq;
   wire pri_hit;
   wire sec_hit;
   wire flag_set;
   wire trig_clear;
   wire period_end;

   // Mode decode helpers
   function is_pwm;
      input [2:0] m;
      begin
         is_pwm = m[2] & m[1];
      end
   endfunction

   function is_double;
      input [2:0] m;
      begin
         is_double = m[2] & ~m[1];
      end
   endfunction

   function default_level;
      input [2:0] m;
      begin
         default_level = (m == `OCU_MODE_ONE_LOW);
      end
   endfunction

   function addr_known;
      input [7:0] a;
      begin
         addr_known = (a == `OCU_ADDR_CTL_ONE) ||
            (a == `OCU_ADDR_CTL_TWO) || (a == `OCU_ADDR_PRIMARY) ||
            (a == `OCU_ADDR_SECONDARY) || (a == `OCU_ADDR_COUNTER) ||
            (a == `OCU_ADDR_STATUS);
      end
   endfunction

   assign compare_mode_select = ctl_one_q[`OCU_MODE_MSB:`OCU_MODE_LSB];
   assign time_base_select = ctl_one_q[`OCU_TBSEL_MSB:`OCU_TBSEL_LSB];
   assign trigger_clear_mode = ctl_one_q[`OCU_TRIG_CLR_BIT];
   assign cascade_enable = ctl_two_q[`OCU_CASCADE_BIT];
   assign trigger_mode_select = ctl_two_q[`OCU_TRIG_SEL_BIT];
   assign sync_source_select = ctl_two_q[`OCU_SYNC_MSB:`OCU_SYNC_LSB];

   // APB: zero wait states, error on unmapped address
   assign addr_ok = addr_known(paddr);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign wr_en = psel & penable & pwrite & addr_ok;
   assign ctl_one_wr = wr_en & (paddr == `OCU_ADDR_CTL_ONE);
   assign ctl_two_wr = wr_en & (paddr == `OCU_ADDR_CTL_TWO);
   assign stat_wr = wr_en & (paddr == `OCU_ADDR_STATUS);

   ocu_tick_sel u_tick (
      .time_base_select(time_base_select),
      .timer_tick(timer_tick),
      .tick(tick)
   );

   ocu_sync_sel u_sync (
      .sync_source_select(sync_source_select),
      .sync_event_in(sync_event_in),
      .self_event(period_end),
      .sync_event(sync_event)
   );

   assign enabled = (compare_mode_select != `OCU_MODE_OFF);
   // nonzero sync select leaves free-running operation
   assign synced = (sync_source_select != `OCU_SYNC_NONE);
   // set bit chooses trigger, clear bit chooses synchronous
   assign trig_op = synced & trigger_mode_select;
   // cascade only when both units have it set
   assign cascaded = cascade_enable & casc_peer_enable;
   assign high_role = cascaded & casc_high_half;
   assign casc_enable_out = cascade_enable;

   // high half steps on the low half roll-over
   assign step = high_role ? casc_carry_in : tick;
   assign held = ~enabled | (trig_op & ~trig_stat_q);
   // sync event clears the counter in synchronous operation
   assign sync_reset = synced & ~trig_op & sync_event;

   // count up, wrap from all ones to zero
   always @*
   begin
      if (held | sync_reset)
         compare_counter_d = `OCU_CNT_ZERO;
      else if (step)
         compare_counter_d = compare_counter_q + 16'h0001;
      else
         compare_counter_d = compare_counter_q;
   end

   // PWM uses shadow copies, compare modes use live values
   assign pri_val = is_pwm(compare_mode_select) ? pri_shadow_q :
      primary_compare_value_q;
   assign sec_val = is_pwm(compare_mode_select) ? sec_shadow_q :
      secondary_compare_value_q;

   // each half compares its own 16 bits, peer supplies the rest
   assign casc_pri_eq = (compare_counter_q == pri_val);
   assign casc_sec_eq = (compare_counter_q == sec_val);
   assign pri_eq = casc_pri_eq & (~cascaded | casc_peer_pri_eq);
   assign sec_eq = casc_sec_eq & (~cascaded | casc_peer_sec_eq);

   // one event per new counter value that matches
   assign pri_hit = enabled & fresh_q & pri_eq;
   assign sec_hit = enabled & fresh_q & sec_eq;

   // edge PWM period ends at secondary match
   // center PWM period follows the sync source
   assign period_end = (compare_mode_select == `OCU_MODE_PWM_CENTER) ?
      sync_event : sec_hit;
   assign period_event = period_end;

   // top mode bit clear marks compare operation
   // flag source depends on single or double compare
   assign flag_set = (~compare_mode_select[2] & pri_hit) |
      (is_double(compare_mode_select) & sec_hit);

   // clear mode lets secondary match clear trigger status
   assign trig_clear = trigger_clear_mode & sec_hit;

   // Pin next state per mode
   always @*
   begin
      pin_d = pin_q;
      case (compare_mode_select)
         `OCU_MODE_OFF:
            pin_d = 1'b0;
         // leave default state on primary match
         `OCU_MODE_ONE_HIGH, `OCU_MODE_ONE_LOW:
            if (pri_hit & armed_q)
               pin_d = ~default_level(compare_mode_select);
         `OCU_MODE_TOGGLE:
            if (pri_hit)
               pin_d = ~pin_q;
         // back to default on secondary match
         `OCU_MODE_DBL_SHOT, `OCU_MODE_DBL_CONT:
            if (armed_q & ~half_q & pri_hit)
               pin_d = 1'b1;
            else if (armed_q & half_q & sec_hit)
               pin_d = 1'b0;
         // edge PWM high from period start to primary match
         `OCU_MODE_PWM_EDGE:
            if (fresh_q & pri_eq)
               pin_d = 1'b0;
            else if (fresh_q & (compare_counter_q == `OCU_CNT_ZERO))
               pin_d = 1'b1;
         // center PWM high from primary to secondary match
         `OCU_MODE_PWM_CENTER:
            if (sec_hit)
               pin_d = 1'b0;
            else if (pri_hit)
               pin_d = 1'b1;
         default:
            pin_d = 1'b0;
      endcase
   end

   assign compare_output_pin = pin_q;
   assign compare_interrupt_flag = flag_q;

   // Register writes
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctl_one_q <= `OCU_CTL_ONE_RST;
         ctl_two_q <= `OCU_CTL_TWO_RST;
         primary_compare_value_q <= `OCU_VALUE_RST;
         secondary_compare_value_q <= `OCU_VALUE_RST;
      end
      else if (wr_en)
      begin
         case (paddr)
            `OCU_ADDR_CTL_ONE:
               ctl_one_q <= pwdata[15:0] & 16'h1c0f;
            `OCU_ADDR_CTL_TWO:
               ctl_two_q <= pwdata[15:0] & 16'h019f;
            `OCU_ADDR_PRIMARY:
               primary_compare_value_q <= pwdata[15:0];
            `OCU_ADDR_SECONDARY:
               secondary_compare_value_q <= pwdata[15:0];
            default:
               ctl_one_q <= ctl_one_q;
         endcase
      end
   end

   // new PWM values wait for the period to end
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pri_shadow_q <= `OCU_VALUE_RST;
         sec_shadow_q <= `OCU_VALUE_RST;
         load_req_q <= 1'b0;
      end
      else if (~is_pwm(compare_mode_select))
      begin
         pri_shadow_q <= primary_compare_value_q;
         sec_shadow_q <= secondary_compare_value_q;
         load_req_q <= 1'b0;
      end
      else
      begin
         if (period_end | load_req_q)
         begin
            pri_shadow_q <= primary_compare_value_q;
            sec_shadow_q <= secondary_compare_value_q;
         end
         load_req_q <= 1'b0;
      end
   end

   // Counter, carry and freshness
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         compare_counter_q <= `OCU_CNT_ZERO;
         fresh_q <= 1'b0;
         casc_carry_out <= 1'b0;
      end
      else
      begin
         compare_counter_q <= compare_counter_d;
         fresh_q <= ~held & (step | sync_reset);
         // roll-over of low half carries into the high half
         casc_carry_out <= ~held & ~sync_reset & step &
            (compare_counter_q == `OCU_CNT_MAX);
      end
   end

   // arm on control one write, single-shot disarms after firing
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         armed_q <= 1'b0;
         half_q <= 1'b0;
      end
      else if (ctl_one_wr)
      begin
         armed_q <= 1'b1;
         half_q <= 1'b0;
      end
      else
      begin
         if (is_double(compare_mode_select))
         begin
            if (armed_q & ~half_q & pri_hit)
               half_q <= 1'b1;
            else if (armed_q & half_q & sec_hit)
            begin
               half_q <= 1'b0;
               if (compare_mode_select == `OCU_MODE_DBL_SHOT)
                  armed_q <= 1'b0;
            end
         end
         else if (pri_hit & (compare_mode_select != `OCU_MODE_TOGGLE))
            armed_q <= 1'b0;
      end
   end

   // Pin: new mode restarts from its default level
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pin_q <= 1'b0;
      else if (ctl_one_wr)
         pin_q <= default_level(pwdata[2:0]);
      else
         pin_q <= pin_d;
   end

   // Flag: write one clears, a new event wins over the clear
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_q <= 1'b0;
      else if (flag_set)
         flag_q <= 1'b1;
      else if (stat_wr & pwdata[`OCU_FLAG_BIT])
         flag_q <= 1'b0;
   end

   // Trigger status: sync event or software sets, clear mode clears
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         trig_stat_q <= 1'b0;
      // trigger event lets the counter run
      else if (trig_op & sync_event)
         trig_stat_q <= 1'b1;
      else if (ctl_two_wr)
         trig_stat_q <= pwdata[`OCU_TRIG_STAT_BIT];
      else if (trig_clear)
         trig_stat_q <= 1'b0;
   end

   // Read data latched in the setup phase
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (psel & ~penable & ~pwrite)
      begin
         case (paddr)
            `OCU_ADDR_CTL_ONE:
               prdata <= {16'h0000, ctl_one_q};
            `OCU_ADDR_CTL_TWO:
               prdata <= {16'h0000, ctl_two_q[15:7], trig_stat_q,
                  ctl_two_q[5:0]};
            `OCU_ADDR_PRIMARY:
               prdata <= {16'h0000, primary_compare_value_q};
            `OCU_ADDR_SECONDARY:
               prdata <= {16'h0000, secondary_compare_value_q};
            `OCU_ADDR_COUNTER:
               prdata <= {16'h0000, compare_counter_q};
            `OCU_ADDR_STATUS:
               prdata <= {30'h00000000, pin_q, flag_q};
            default:
               prdata <= 32'h00000000;
         endcase
      end
   end

endmodule // ocu_unit
`default_nettype wire

// ===== ocu_unit_monitor.sv
// Port checker for ocu_unit: pin, flag, cascade and PWM timing.
// Assumes it is bound to ocu_unit and sees only its ports.
`default_nettype none
module ocu_unit_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic casc_enable_out,
   input wire logic casc_carry_out,
   input wire logic casc_pri_eq,
   input wire logic casc_sec_eq,
   input wire logic period_event,
   input wire logic compare_interrupt_flag,
   input wire logic compare_output_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] mode_q;
   logic wr1;
   logic wr2;
   assign wr1 = psel && penable && pwrite && paddr == 8'h00;
   assign wr2 = psel && penable && pwrite && paddr == 8'h04;
   // Mode field as software last wrote it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mode_q <= 3'h0;
      else if (wr1)
         mode_q <= pwdata[2:0];
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_off;
      mode_q == 3'h0 && $past(mode_q) == 3'h0 |-> !compare_output_pin;
   endproperty
   a_off: assert property (p_off)
      else $error("pin high while unit off");
   property p_pin;
      mode_q != 3'h0 && !mode_q[2] && !$past(wr1) && !$past(wr1, 2)
         && $changed(compare_output_pin) |-> $past(casc_pri_eq);
   endproperty
   a_pin: assert property (p_pin)
      else $error("pin moved without primary match");
   property p_dbl;
      mode_q[2:1] == 2'b10 && !$past(wr1) && $fell(compare_output_pin)
         |-> $past(casc_sec_eq);
   endproperty
   a_dbl: assert property (p_dbl)
      else $error("pin fell without secondary match");
   property p_flag1;
      !mode_q[2] && $rose(compare_interrupt_flag) |-> $past(casc_pri_eq);
   endproperty
   a_flag1: assert property (p_flag1)
      else $error("flag set without primary match");
   property p_flag2;
      mode_q[2:1] == 2'b10 && $rose(compare_interrupt_flag)
         |-> $past(casc_sec_eq);
   endproperty
   a_flag2: assert property (p_flag2)
      else $error("flag set without secondary match");
   property p_shot;
      mode_q == 3'h1 && compare_output_pin && !wr1 |=> compare_output_pin;
   endproperty
   a_shot: assert property (p_shot)
      else $error("single shot pin dropped");
   property p_carry;
      casc_carry_out |=> !casc_carry_out;
   endproperty
   a_carry: assert property (p_carry)
      else $error("carry longer than one cycle");
   property p_casc;
      wr2 |=> casc_enable_out == $past(pwdata[8]);
   endproperty
   a_casc: assert property (p_casc)
      else $error("cascade enable not taken");
   property p_per;
      mode_q == 3'h6 && casc_sec_eq |-> period_event;
   endproperty
   a_per: assert property (p_per)
      else $error("no period end on secondary match");
endmodule // ocu_unit_chk
bind ocu_unit ocu_unit_chk ocu_unit_chk_i (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .casc_enable_out, .casc_carry_out,
   .casc_pri_eq, .casc_sec_eq, .period_event, .compare_interrupt_flag,
   .compare_output_pin);
`default_nettype wire

// ===== testbench.sv
// Testbench for ocu_unit: APB register tasks and compare scenarios.
// Assumes a zero wait APB slave and the pin load model.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd_q;
   logic [4:0] timer_tick;
   logic [30:1] sync_event_in;
   logic [15:0] timer_period_value, high_cnt;
   logic casc_high_half, casc_peer_enable, casc_carry_in;
   logic casc_enable_out, casc_carry_out, casc_pri_eq, casc_sec_eq;
   logic period_event, compare_interrupt_flag, compare_output_pin;
   logic [2:0] pls_q;
   logic err_q, clr_q;
   int n_errors = 0;
   int checks_done = 0;
   assign timer_tick = {4'h0, pls_q[0]};
   assign casc_carry_in = pls_q[1];
   assign sync_event_in = {29'h0, pls_q[2]};
   ocu_unit ocu_unit_i (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_tick,
      .sync_event_in, .timer_period_value, .casc_high_half,
      .casc_peer_enable, .casc_carry_in, .casc_peer_pri_eq(1'b0),
      .casc_peer_sec_eq(1'b0), .casc_enable_out, .casc_carry_out,
      .casc_pri_eq, .casc_sec_eq, .period_event, .compare_interrupt_flag,
      .compare_output_pin);
   ocu_pin_load ocu_pin_load_i (.pclk, .clr(clr_q),
      .pin(compare_output_pin), .high_cnt);
   initial
   begin
      pclk = 1'b0;
      forever
         #20 pclk = ~pclk;
   end
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd_q, e);
   endtask
   task automatic pulse(input int k, input int n);
      repeat (n)
      begin
         @(posedge pclk);
         pls_q[k] <= 1'b1;
         @(posedge pclk);
         pls_q[k] <= 1'b0;
      end
   endtask
   initial
   begin
      #(40 * 80000);
      n_errors++;
      report_and_stop();
   end
   initial
   begin
      int n;
      presetn <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 8'h0;
      pwdata <= 32'h0;
      pls_q <= 3'h0;
      clr_q <= 1'b0;
      timer_period_value <= 16'h0010;
      casc_high_half <= 1'b0;
      casc_peer_enable <= 1'b0;
      cyc(12);
      presetn <= 1'b1;
      for (int a = 0; a < 28; a += 4)
         rdc(a[7:0], 32'h0);
      chk({31'h0, err_q}, 32'h1);
      wr(8'h08, 32'h5);
      for (int m = 1; m < 4; m++)
      begin
         wr(8'h00, 32'h0);
         wr(8'h00, 32'h1c00 | m);
         cyc(12);
         rdc(8'h14, m == 2 ? 32'h1 : 32'h3);
         wr(8'h14, 32'h1);
      end
      rdc(8'h14, 32'h2);
      chk({31'h0, compare_interrupt_flag}, 32'h0);
      wr(8'h0c, 32'h10);
      wr(8'h04, 32'h1);
      for (int m = 4; m < 6; m++)
      begin
         wr(8'h00, 32'h0);
         wr(8'h00, 32'h1c00 | m);
         cyc(24);
         rdc(8'h14, 32'h1);
         wr(8'h14, 32'h1);
         pulse(2, 1);
         cyc(9);
         chk({31'h0, compare_output_pin}, m - 4);
      end
      wr(8'h00, 32'h0);
      wr(8'h0c, 32'h14);
      wr(8'h08, 32'h100);
      wr(8'h04, 32'h81);
      wr(8'h00, 32'h1c09);
      cyc(5);
      rdc(8'h10, 32'h0);
      pulse(2, 1);
      rdc(8'h04, 32'hc1);
      cyc(40);
      rdc(8'h04, 32'h81);
      rdc(8'h10, 32'h0);
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h0);
      wr(8'h00, 32'h1);
      pulse(0, 7);
      rdc(8'h10, 32'h7);
      casc_high_half <= 1'b1;
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h100);
      wr(8'h00, 32'h1);
      chk({31'h0, casc_enable_out}, 32'h1);
      pulse(1, 3);
      rdc(8'h10, 32'h0);
      casc_peer_enable <= 1'b1;
      pulse(1, 3);
      rdc(8'h10, 32'h3);
      casc_high_half <= 1'b0;
      casc_peer_enable <= 1'b0;
      wr(8'h08, 32'h3);
      wr(8'h0c, 32'h9);
      wr(8'h04, 32'h1f);
      wr(8'h00, 32'h1c06);
      for (int k = 0; k < 2; k++)
      begin
         cyc(20);
         clr_q <= 1'b1;
         @(posedge pclk);
         clr_q <= 1'b0;
         cyc(31);
         chk({16'h0, high_cnt}, k ? 32'hf : 32'h9);
         wr(8'h08, 32'h5);
      end
      rdc(8'h08, 32'h5);
      wr(8'h00, 32'h0);
      wr(8'h08, 32'h2);
      wr(8'h0c, 32'h4);
      wr(8'h04, 32'h1);
      wr(8'h00, 32'h1c07);
      pulse(2, 1);
      cyc(4);
      chk({31'h0, compare_output_pin}, 32'h1);
      cyc(2);
      chk({31'h0, compare_output_pin}, 32'h0);
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h0);
      wr(8'h08, 32'hfff0);
      wr(8'h00, 32'h1c01);
      n = 0;
      while (casc_carry_out !== 1'b1 && n < 70000)
      begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, casc_carry_out}, 32'h1);
      chk({31'h0, n > 65500}, 32'h1);
      chk({31'h0, compare_output_pin}, 32'h1);
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
